/* shared/dus_pkg.sv */
package dus_pkg;

    // command opcodes (data/command select low)
    localparam logic [7:0] OP_ACTIVATE = 8'h20;
    localparam logic [7:0] OP_CTRL1    = 8'h21;
    localparam logic [7:0] OP_CTRL2    = 8'h22;
    localparam logic [7:0] OP_NONE     = 8'h00;

    // first update control fields
    localparam int C1_BYPASS_BIT = 7;
    localparam int C1_VALUE_BIT  = 4;
    localparam int C1_OPT_LSB    = 0;

    // second update control stage bits, in execution order
    localparam int C2_CLK_ON   = 7;
    localparam int C2_CP_ON    = 6;
    localparam int C2_TEMP     = 5;
    localparam int C2_LUT      = 4;
    localparam int C2_INIT     = 3;
    localparam int C2_PATTERN  = 2;
    localparam int C2_CP_OFF   = 1;
    localparam int C2_CLK_OFF  = 0;

    localparam logic [7:0] CTRL2_RESET = 8'hff;
    localparam logic [2:0] STAGE_FIRST = 3'h0;
    localparam logic [2:0] STAGE_LAST  = 3'h7;
    localparam logic [2:0] BIT_LAST    = 3'h7;

    // handshake stage index: temp, lut, initial, pattern
    localparam int REQ_TEMP    = 0;
    localparam int REQ_LUT     = 1;
    localparam int REQ_INIT    = 2;
    localparam int REQ_PATTERN = 3;

    typedef struct packed {
        logic       bypass_enable;
        logic       bypass_value;
        logic [1:0] init_option;
    } dus_ctrl1_s;

    localparam dus_ctrl1_s CTRL1_RESET = '{1'b0, 1'b0, 2'h0};

    typedef struct packed {
        logic [7:0] data;
        logic       is_param;
    } dus_byte_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SCAN,
        SEQ_WAIT
    } dus_seq_e;

endpackage

/* core/dus_sync3.sv */
`timescale 1ns/10ps
`default_nettype none
module dus_sync3 (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic d,
    input  wire logic init,
    output var  logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // filtered level holds its idle value until the chain has filled,
    // so reset zeros in the chain never show as a false pin change;
    // afterwards it follows only once stages two and three agree
    logic [1:0] fill_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q        <= 1'b0;
            fill_reg <= 2'h0;
        end else if (!(&fill_reg)) begin
            fill_reg <= fill_reg + 2'h1;
            q        <= init;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule
`default_nettype wire

/* core/dus_update_ctrl.sv */
// Summary of operation
// - opcode 0x21 then one byte stores bypass, bypass value, initial option
// - first-control bit 7 set bypasses old-frame RAM; default off
// - during bypass, first-control bit 4 replaces the RAM data; default 0
// - first-control bits 1:0 pick the initial-update source option
// - opcode 0x22 then one byte selects stages for the next activation
// - default 0xff runs all eight stages in their fixed order
// - 0x80 only enables clock; 0xc0 enables clock then charge pump
// - 0x0c runs initial then pattern display; 0x08 only initial display
// - 0x03 disables charge pump then disables clock
// - 0x01 only disables the clock
// - clock enable turns on oscillator if strap high, else external clock
// - clock enable cleared with strap high turns oscillator off
// - stages run only on opcode 0x20; host must not interrupt
`timescale 1ns/10ps
`default_nettype none
module dus_update_ctrl (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                spi_sclk,
    input  wire logic                spi_mosi,
    input  wire logic                spi_cs_n,
    input  wire logic                spi_dc,
    input  wire logic                clock_source_strap,
    input  wire logic [3:0]          stage_done,
    output var  logic [3:0]          stage_req,
    output var  dus_pkg::dus_ctrl1_s ctrl1,
    output var  logic                clock_gate_enable,
    output var  logic                charge_pump_enable,
    output var  logic                internal_oscillator_en,
    output var  logic                ext_clock_en,
    output var  logic                busy
);
    import dus_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sclk_s;
    logic mosi_s;
    logic cs_n_s;
    logic dc_s;
    logic strap_s;

    dus_sync3 u_sync_sclk (
        .clk  (clk),
        .nrst (nrst),
        .d    (spi_sclk),
        .init (1'b0),
        .q    (sclk_s)
    );
    dus_sync3 u_sync_mosi (
        .clk  (clk),
        .nrst (nrst),
        .d    (spi_mosi),
        .init (1'b0),
        .q    (mosi_s)
    );
    dus_sync3 u_sync_cs (
        .clk  (clk),
        .nrst (nrst),
        .d    (spi_cs_n),
        .init (1'b1),
        .q    (cs_n_s)
    );
    dus_sync3 u_sync_dc (
        .clk  (clk),
        .nrst (nrst),
        .d    (spi_dc),
        .init (1'b0),
        .q    (dc_s)
    );
    dus_sync3 u_sync_strap (
        .clk  (clk),
        .nrst (nrst),
        .d    (clock_source_strap),
        .init (1'b0),
        .q    (strap_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial byte receiver, msb first, sampled on rising clock edge
    logic      sclk_prev_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    dus_byte_s rx_reg;
    logic      rx_valid_reg;
    logic      sclk_rise;

    assign sclk_rise = sclk_s && !sclk_prev_reg && !cs_n_s;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 7'h00;
            rx_reg       <= '0;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            if (cs_n_s) begin
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg   <= {shift_reg[5:0], mosi_s};
                if (bit_cnt_reg == BIT_LAST) begin
                    rx_reg.data     <= {shift_reg, mosi_s};
                    rx_reg.is_param <= dc_s;
                    rx_valid_reg    <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode and update control registers
    logic [7:0] last_op_reg;
    logic [7:0] ctrl2_reg;
    logic       activate;

    assign activate = rx_valid_reg && !rx_reg.is_param
                      && rx_reg.data == OP_ACTIVATE;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_op_reg <= OP_NONE;
        end else if (rx_valid_reg && !rx_reg.is_param) begin
            last_op_reg <= rx_reg.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl1 <= CTRL1_RESET;
        end else if (rx_valid_reg && rx_reg.is_param
                     && last_op_reg == OP_CTRL1) begin
            ctrl1.bypass_enable <= rx_reg.data[C1_BYPASS_BIT];
            ctrl1.bypass_value  <= rx_reg.data[C1_VALUE_BIT];
            ctrl1.init_option   <= rx_reg.data[C1_OPT_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl2_reg <= CTRL2_RESET;
        end else if (rx_valid_reg && rx_reg.is_param
                     && last_op_reg == OP_CTRL2) begin
            ctrl2_reg <= rx_reg.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // staged update sequencer
    dus_seq_e   state_reg;
    logic [2:0] stage_reg;
    logic [7:0] sel_reg;
    logic [1:0] wait_idx_reg;
    logic       stage_on;
    logic       stage_is_hs;
    logic [1:0] hs_idx;

    // stage index n maps to control bit 7-n
    assign stage_on    = sel_reg[BIT_LAST - stage_reg];
    assign stage_is_hs = stage_reg >= 3'(BIT_LAST - C2_TEMP)
                         && stage_reg <= 3'(BIT_LAST - C2_PATTERN);
    assign hs_idx      = 2'(stage_reg - 3'(BIT_LAST - C2_TEMP));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= SEQ_IDLE;
            stage_reg    <= STAGE_FIRST;
            sel_reg      <= 8'h00;
            wait_idx_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    if (activate) begin
                        sel_reg   <= ctrl2_reg;
                        stage_reg <= STAGE_FIRST;
                        state_reg <= SEQ_SCAN;
                    end
                end
                SEQ_SCAN: begin
                    if (stage_on && stage_is_hs) begin
                        wait_idx_reg <= hs_idx;
                        state_reg    <= SEQ_WAIT;
                    end else if (stage_reg == STAGE_LAST) begin
                        state_reg <= SEQ_IDLE;
                    end else begin
                        stage_reg <= stage_reg + 3'h1;
                    end
                end
                SEQ_WAIT: begin
                    if (stage_done[wait_idx_reg]) begin
                        if (stage_reg == STAGE_LAST) begin
                            state_reg <= SEQ_IDLE;
                        end else begin
                            stage_reg <= stage_reg + 3'h1;
                            state_reg <= SEQ_SCAN;
                        end
                    end
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // one-cycle start pulse for temperature, lut and display stages
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_req <= 4'h0;
        end else begin
            stage_req <= 4'h0;
            if (state_reg == SEQ_SCAN && stage_on && stage_is_hs) begin
                stage_req[hs_idx] <= 1'b1;
            end
        end
    end

    // activation opcodes are ignored until the sequence ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != SEQ_IDLE || activate)
                    && !(state_reg == SEQ_SCAN && stage_reg == STAGE_LAST
                         && !(stage_on && stage_is_hs))
                    && !(state_reg == SEQ_WAIT && stage_reg == STAGE_LAST
                         && stage_done[wait_idx_reg]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock and charge pump flags
    logic scan_act;

    assign scan_act = state_reg == SEQ_SCAN && stage_on;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clock_gate_enable <= 1'b0;
        end else if (scan_act && stage_reg == 3'(BIT_LAST - C2_CLK_ON)) begin
            clock_gate_enable <= 1'b1;
        end else if (scan_act
                     && stage_reg == 3'(BIT_LAST - C2_CLK_OFF)) begin
            clock_gate_enable <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            charge_pump_enable <= 1'b0;
        end else if (scan_act && stage_reg == 3'(BIT_LAST - C2_CP_ON)) begin
            charge_pump_enable <= 1'b1;
        end else if (scan_act && stage_reg == 3'(BIT_LAST - C2_CP_OFF)) begin
            charge_pump_enable <= 1'b0;
        end
    end

    // clock source follows the strap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            internal_oscillator_en <= 1'b0;
            ext_clock_en           <= 1'b0;
        end else begin
            internal_oscillator_en <= clock_gate_enable && strap_s;
            ext_clock_en           <= clock_gate_enable && !strap_s;
        end
    end

endmodule
`default_nettype wire

/* verification/dus_update_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dus_update_ctrl_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       clock_source_strap,
    input wire logic [3:0] stage_req,
    input wire logic       clock_gate_enable,
    input wire logic       charge_pump_enable,
    input wire logic       internal_oscillator_en,
    input wire logic       ext_clock_en,
    input wire logic       busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // strap settled long enough to pass its synchroniser
    sequence s_strap_hi;
        clock_source_strap && $past(clock_source_strap, 6);
    endsequence
    sequence s_strap_lo;
        !clock_source_strap && !$past(clock_source_strap, 6);
    endsequence
    a_osc_on: assert property (clock_gate_enable ##0 s_strap_hi
        |=> internal_oscillator_en) else $error("oscillator not on");
    a_ext_on: assert property (clock_gate_enable ##0 s_strap_lo
        |=> ext_clock_en) else $error("external clock not on");
    a_clk_off: assert property (!clock_gate_enable
        |=> !internal_oscillator_en && !ext_clock_en)
        else $error("clock source left on");
    a_req_onehot: assert property ($onehot0(stage_req))
        else $error("two stages started at once");
    a_req_pulse: assert property (stage_req != 4'h0
        |=> stage_req == 4'h0) else $error("stage request too long");
    a_req_busy: assert property (stage_req != 4'h0 |-> busy)
        else $error("stage started while idle");
    a_clk_held: assert property ($changed(clock_gate_enable)
        |-> busy || $past(busy)) else $error("clock flag moved idle");
    a_cp_held: assert property ($changed(charge_pump_enable)
        |-> busy || $past(busy)) else $error("pump flag moved idle");
    a_cp_order: assert property ($rose(charge_pump_enable)
        |-> clock_gate_enable) else $error("pump on before clock");
endmodule
bind dus_update_ctrl dus_update_ctrl_chk i_dus_update_ctrl_chk (
    .clk                    (clk),
    .nrst                   (nrst),
    .clock_source_strap     (clock_source_strap),
    .stage_req              (stage_req),
    .clock_gate_enable      (clock_gate_enable),
    .charge_pump_enable     (charge_pump_enable),
    .internal_oscillator_en (internal_oscillator_en),
    .ext_clock_en           (ext_clock_en),
    .busy                   (busy)
);
`default_nettype wire

/* verification/dus_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dus_host_model (
    input  wire logic clk,
    output var  logic spi_sclk,
    output var  logic spi_mosi,
    output var  logic spi_cs_n,
    output var  logic spi_dc
);
    initial begin
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        spi_cs_n = 1'b1;
        spi_dc   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one byte, msb first; serial clock idles low between frames
    task automatic send(input logic [7:0] b, input logic dc);
        tick(1);
        spi_cs_n = 1'b0;
        spi_dc   = dc;
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = b[i];
            tick(5);
            spi_sclk = 1'b1;
            tick(5);
            spi_sclk = 1'b0;
        end
        spi_cs_n = 1'b1;
        // released data line must not keep its last level
        spi_mosi = ~b[0];
        tick(4);
    endtask
endmodule
`default_nettype wire

/* verification/display_update_sequence_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module display_update_sequence_control_test;
    import dus_pkg::*;
    logic        clk = 1'b0;
    logic        nrst;
    logic        strap;
    logic        sclk;
    logic        mosi;
    logic        cs_n;
    logic        dc;
    logic [3:0]  done;
    logic [3:0]  req;
    logic [3:0]  pend;
    logic [3:0]  exp_req;
    dus_ctrl1_s  ctrl1;
    logic        cge;
    logic        cpe;
    logic        osc;
    logic        ext;
    logic        busy;
    logic        exp_clk;
    logic        exp_cp;
    logic [31:0] lfsr = 32'd73136;
    logic [3:0]  exp_q[$];
    int          dly;
    int          n_errors;
    int          checks_done;

    always #10 clk = ~clk;

    dus_host_model i_dus_host_model (.clk(clk), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_cs_n(cs_n), .spi_dc(dc));
    dus_update_ctrl i_dus_update_ctrl (.clk(clk), .nrst(nrst),
        .spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_n(cs_n), .spi_dc(dc),
        .clock_source_strap(strap), .stage_done(done), .stage_req(req),
        .ctrl1(ctrl1), .clock_gate_enable(cge), .charge_pump_enable(cpe),
        .internal_oscillator_en(osc), .ext_clock_en(ext), .busy(busy));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // stage partner: compares each request, answers after random delay
    always @(posedge clk) begin
        #1;
        if (req !== 4'h0) begin
            exp_req = exp_q.size() ? exp_q.pop_front() : 4'h0;
            check("stage_req", exp_req, req);
            pend = req;
            lfsr = lfsr_next(lfsr);
            dly = lfsr[2:0];
        end
        done = 4'h0;
        if (pend != 4'h0) begin
            if (dly == 0) begin
                done = pend;
                pend = 4'h0;
            end else begin
                dly--;
            end
        end
    end

    task automatic run(input logic [7:0] code, input logic s,
                       input logic wr);
        int n;
        strap = s;
        if (code[7]) exp_clk = 1'b1;
        if (code[6]) exp_cp = 1'b1;
        if (code[1]) exp_cp = 1'b0;
        if (code[0]) exp_clk = 1'b0;
        for (int i = 5; i >= 2; i--) begin
            if (code[i]) exp_q.push_back(4'h1 << (5 - i));
        end
        if (wr) begin
            i_dus_host_model.send(OP_CTRL2, 1'b0);
            i_dus_host_model.send(code, 1'b1);
        end
        i_dus_host_model.send(OP_ACTIVATE, 1'b0);
        repeat (4) @(posedge clk);
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) begin
            n_errors++;
            $display("unexpected busy: expected 0, seen %b", busy);
            end_sim();
        end
        repeat (3) @(posedge clk);
        #1;
        check("clock_gate_enable", exp_clk, cge);
        check("charge_pump_enable", exp_cp, cpe);
        check("internal_oscillator_en", exp_clk & s, osc);
        check("ext_clock_en", exp_clk & ~s, ext);
        check("stages pending", 8'h0, 8'(exp_q.size()));
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        strap = 1'b1;
        done = 4'h0;
        pend = 4'h0;
        dly = 0;
        exp_clk = 1'b0;
        exp_cp = 1'b0;
        n_errors = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("ctrl1", 8'h0, ctrl1);
        i_dus_host_model.send(8'h55, 1'b1);
        check("ctrl1", 8'h0, ctrl1);
        i_dus_host_model.send(OP_CTRL1, 1'b0);
        i_dus_host_model.send(8'h93, 1'b1);
        check("ctrl1", 8'h0f, ctrl1);
        repeat (3) begin
            lfsr = lfsr_next(lfsr);
            i_dus_host_model.send(lfsr[7:0], 1'b1);
            check("ctrl1", {lfsr[7], lfsr[4], lfsr[1:0]}, ctrl1);
        end
        run(8'hff, 1'b1, 1'b0);
        run(8'h80, 1'b1, 1'b1);
        run(8'h01, 1'b1, 1'b1);
        run(8'hc0, 1'b0, 1'b1);
        run(8'h03, 1'b0, 1'b1);
        run(8'h0c, 1'b1, 1'b1);
        run(8'h08, 1'b0, 1'b1);
        // second reset: both update controls must return to defaults
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("ctrl1", 8'h0, ctrl1);
        run(8'hff, 1'b0, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
